// ===== logic/ezl_pkg.sv
// shared constants for the eeprom configuration zone loader
package ezl_pkg;
    localparam logic [11:0] HDR_SIGNATURE   = 12'h5a3; // arbitrary
    localparam int          HDR_ZONE1_BIT   = 2;
    localparam int          HDR_ZONE2_BIT   = 1;
    localparam int          HDR_ZONE3_BIT   = 0;
    localparam int          WORD_MORE_BIT   = 15;
    localparam int          FUNC_COUNT      = 2;
    localparam logic [6:0]  LC_CONTROL      = 7'h00;
    localparam logic [6:0]  LC_MPIN_CFG0    = 7'h04;
    localparam logic [6:0]  LC_MPIN_CFG2    = 7'h06;
    localparam logic [6:0]  LC_TIMING_LO    = 7'h08;
    localparam logic [6:0]  LC_TIMING_HI    = 7'h0d;
    localparam logic [6:0]  LC_TIMING_BLK   = 7'h0e;
    localparam logic [6:0]  LC_TIMING_TOP   = 7'h0f;
    localparam logic [6:0]  LC_IRQ_MASK_LO  = 7'h1e;
    localparam logic [6:0]  LC_IRQ_MASK_HI  = 7'h1f;
    localparam logic [7:0]  LC_CONTROL_MASK = 8'hfc;
    localparam logic [7:0]  LC_BLK_MASK     = 8'hf0;
    localparam logic [7:0]  LC_TOP_MASK     = 8'hdf;
    localparam logic [6:0]  ID_VENDOR_LO    = 7'h00;
    localparam logic [6:0]  ID_SUBVEND_HI   = 7'h03;
    localparam logic [2:0]  FN_UART         = 3'h0;
    localparam logic [2:0]  FN_LOCAL        = 3'h1;
    localparam logic [6:0]  PC_DEVICE_LO    = 7'h02;
    localparam logic [6:0]  PC_DEVICE_HI    = 7'h03;
    localparam logic [6:0]  PC_STATUS       = 7'h06;
    localparam logic [6:0]  PC_CLASS_LO     = 7'h09;
    localparam logic [6:0]  PC_CLASS_HI     = 7'h0b;
    localparam logic [6:0]  PC_SUBSYS_LO    = 7'h2e;
    localparam logic [6:0]  PC_SUBSYS_HI    = 7'h2f;
    localparam logic [6:0]  PC_INT_PIN      = 7'h3d;
    localparam logic [6:0]  PC_PM_LO        = 7'h42;
    localparam logic [6:0]  PC_PM_HI        = 7'h43;
    localparam logic [7:0]  PC_STATUS_MASK  = 8'h10;
    localparam logic [7:0]  LC_CONTROL_RST  = 8'h00;
    localparam logic [23:0] MPIN_CFG_RST    = 24'h000000;
    localparam logic [31:0] TIMING_RST      = 32'h00000000;
    localparam logic [15:0] IRQ_MASK_RST    = 16'h0000;
    localparam logic [15:0] VENDOR_ID_RST   = 16'h0abc; // arbitrary
    localparam logic [15:0] SUBVEND_ID_RST  = 16'h0000; // arbitrary
    localparam logic [15:0] DEVICE_ID_RST   = 16'h0001; // arbitrary
    localparam logic [23:0] CLASS_RST       = 24'h000000;
    localparam logic [15:0] SUBSYS_RST      = 16'h0000;
    localparam logic [7:0]  INT_PIN_RST     = 8'h01;
    localparam logic [15:0] PM_CAP_RST      = 16'h0000;
    localparam logic [7:0]  STATUS_RST      = 8'h10;
endpackage : ezl_pkg

// ===== logic/ezl_word_fetch.sv
// sequential word address generator and request handshake
`timescale 1ns/1ps
module ezl_word_fetch #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // control
    input  wire logic              start,
    input  wire logic              advance,
    // word reader
    output logic                   req,
    output logic [ADDR_W-1:0]      addr,
    input  wire logic              done
);
    initial begin
        if (ADDR_W < 6 || ADDR_W > 16)
            $error("ADDR_W out of range");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req  <= 1'b0;
            addr <= '0;
        end else if (start) begin
            req  <= 1'b1;
            addr <= '0;
        end else if (advance) begin
            // advance outranks done: next word asked on the answer edge
            req  <= 1'b1;
            addr <= addr + ADDR_W'(1);
        end else if (done) begin
            req <= 1'b0;
        end
    end
endmodule : ezl_word_fetch

// ===== logic/ezl_loader.sv
// zone parser applying eeprom words to local and pci configuration
`timescale 1ns/1ps
// Function
// - zone1 words follow header only when header bit 2 set
// - zone1 word bit 15 low ends zone1, high means more follow
// - zone1 word is 7-bit byte offset 14:8 plus value 7:0
// - byte 0x00 loads local control fields, bits 1:0 forced zero
// - bytes 0x04-0x06 pin config, 0x08-0x0d timing bytes
// - bytes 0x0e and 0x0f load block size, decode, clock, type
// - bytes 0x1e and 0x1f load interrupt mask bits
// - zone2 word bit 15 low ends zone2, high means more
// - zone2 codes 0..3 select vendor and subsystem vendor bytes
// - zone3 holds up to two function groups
// - zone3 header bit 15 low ends zone3, bits 2:0 pick function
// - zone3 data word writes byte at offset of chosen function 0 or 1
// - zone3 programs device id, status bit 4, power caps
// - zone3 programs class code bytes 0x09 to 0x0b
// - zone3 programs subsystem id and interrupt pin bytes
// - header 15:4 must match signature, then valid flag set
// - header bits 2..0 flag zones, present zones are contiguous
// - load starts after bus reset, ends on absence, bad signature or data end
// - eeprom read as 16-bit words, one request per word
module ezl_loader #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // word reader
    output logic                   WORD_REQ,
    output logic [ADDR_W-1:0]      WORD_ADDR,
    input  wire logic              WORD_DONE,
    input  wire logic              WORD_ABSENT,
    input  wire logic [15:0]       WORD_DATA,
    // local configuration
    output logic [7:0]             LOCAL_CONTROL,
    output logic [23:0]            MULTIPURPOSE_PIN_CONFIG,
    output logic [31:0]            LOCAL_BUS_TIMING_FIRST,
    output logic [31:0]            LOCAL_BUS_TIMING_SECOND,
    output logic [15:0]            GLOBAL_INTERRUPT_SUMMARY_MASK,
    // identification
    output logic [15:0]            VENDOR_ID,
    output logic [15:0]            SUBSYS_VENDOR_ID,
    // per-function pci configuration, function n in slice n
    output logic [31:0]            DEVICE_ID,
    output logic [15:0]            STATUS_BYTE,
    output logic [47:0]            CLASS_CODE,
    output logic [31:0]            SUBSYS_ID,
    output logic [15:0]            INT_PIN,
    output logic [31:0]            PM_CAP,
    // status
    output logic                   PROGRAM_VALID,
    output logic                   LOAD_DONE
);
    typedef enum logic [2:0] {
        S_START, S_HEADER, S_ZONE1, S_ZONE2, S_FHDR, S_FDATA, S_DONE
    } ezl_state_type;

    ezl_state_type state_reg;
    ezl_state_type state_next;
    logic [2:0]    zones_reg;
    logic [2:0]    func_reg;
    logic [1:0]    groups_reg;
    logic          sync_q;
    logic          start;
    logic          advance;
    logic          more;
    logic [6:0]    offs;
    logic [7:0]    val;
    logic          func_ok;
    logic          fidx;

    assign more    = WORD_DATA[ezl_pkg::WORD_MORE_BIT];
    assign offs    = WORD_DATA[14:8];
    assign val     = WORD_DATA[7:0];
    assign func_ok = (func_reg == ezl_pkg::FN_UART)
                  || (func_reg == ezl_pkg::FN_LOCAL);
    assign fidx    = func_reg[0];

    // next zone after the current one, given remaining presence bits
    function automatic ezl_state_type next_zone(input logic [2:0] z);
        if (z[ezl_pkg::HDR_ZONE1_BIT])
            next_zone = S_ZONE1;
        else if (z[ezl_pkg::HDR_ZONE2_BIT])
            next_zone = S_ZONE2;
        else if (z[ezl_pkg::HDR_ZONE3_BIT])
            next_zone = S_FHDR;
        else
            next_zone = S_DONE;
    endfunction : next_zone

    // start one cycle after reset release
    always_ff @(posedge MCLK) begin
        if (RST)
            sync_q <= 1'b0;
        else
            sync_q <= 1'b1;
    end
    assign start = (state_reg == S_START) && sync_q;

    ezl_word_fetch #(.ADDR_W(ADDR_W)) u_fetch (
        .clk     (MCLK),
        .rst     (RST),
        .start   (start),
        .advance (advance),
        .req     (WORD_REQ),
        .addr    (WORD_ADDR),
        .done    (WORD_DONE)
    );

    // fetch next word only when the parser still wants data
    assign advance = WORD_DONE && !WORD_ABSENT
                   && (state_next != S_DONE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_START: begin
                if (start)
                    state_next = S_HEADER;
            end
            S_HEADER: begin
                if (WORD_DONE) begin
                    if (WORD_ABSENT
                        || WORD_DATA[15:4] != ezl_pkg::HDR_SIGNATURE)
                        state_next = S_DONE;
                    else
                        state_next = next_zone(WORD_DATA[2:0]);
                end
            end
            S_ZONE1: begin
                if (WORD_DONE && !more)
                    state_next = next_zone(zones_reg & 3'b011);
            end
            S_ZONE2: begin
                if (WORD_DONE && !more)
                    state_next = next_zone(zones_reg & 3'b001);
            end
            S_FHDR: begin
                if (WORD_DONE)
                    state_next = more ? S_FDATA : S_DONE;
            end
            S_FDATA: begin
                if (WORD_DONE && !more)
                    state_next = (groups_reg == 2'(ezl_pkg::FUNC_COUNT))
                               ? S_DONE : S_FHDR;
            end
            default: state_next = S_DONE;
        endcase
        if (state_reg != S_START && state_reg != S_DONE
            && WORD_DONE && WORD_ABSENT)
            state_next = S_DONE;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            state_reg <= S_START;
        else
            state_reg <= state_next;
    end

    // header capture and zone3 group tracking
    always_ff @(posedge MCLK) begin
        if (RST) begin
            zones_reg     <= 3'h0;
            func_reg      <= 3'h0;
            groups_reg    <= 2'h0;
            PROGRAM_VALID <= 1'b0;
            LOAD_DONE     <= 1'b0;
        end else begin
            LOAD_DONE <= (state_next == S_DONE);
            if (state_reg == S_HEADER && WORD_DONE && !WORD_ABSENT
                && WORD_DATA[15:4] == ezl_pkg::HDR_SIGNATURE) begin
                zones_reg     <= WORD_DATA[2:0];
                PROGRAM_VALID <= 1'b1;
            end
            if (state_reg == S_FHDR && WORD_DONE && more) begin
                func_reg   <= WORD_DATA[2:0];
                groups_reg <= groups_reg + 2'h1;
            end
        end
    end

    // zone1: local configuration bytes; other offsets ignored
    always_ff @(posedge MCLK) begin
        if (RST) begin
            LOCAL_CONTROL                 <= ezl_pkg::LC_CONTROL_RST;
            MULTIPURPOSE_PIN_CONFIG       <= ezl_pkg::MPIN_CFG_RST;
            LOCAL_BUS_TIMING_FIRST        <= ezl_pkg::TIMING_RST;
            LOCAL_BUS_TIMING_SECOND       <= ezl_pkg::TIMING_RST;
            GLOBAL_INTERRUPT_SUMMARY_MASK <= ezl_pkg::IRQ_MASK_RST;
        end else if (state_reg == S_ZONE1 && WORD_DONE
                     && !WORD_ABSENT) begin
            if (offs == ezl_pkg::LC_CONTROL) begin
                LOCAL_CONTROL <= val & ezl_pkg::LC_CONTROL_MASK;
            end else if (offs >= ezl_pkg::LC_MPIN_CFG0
                         && offs <= ezl_pkg::LC_MPIN_CFG2) begin
                MULTIPURPOSE_PIN_CONFIG[offs[1:0]*8 +: 8] <= val;
            end else if (offs >= ezl_pkg::LC_TIMING_LO
                         && offs <= ezl_pkg::LC_TIMING_HI) begin
                if (!offs[2])
                    LOCAL_BUS_TIMING_FIRST[offs[1:0]*8 +: 8] <= val;
                else
                    LOCAL_BUS_TIMING_SECOND[offs[0]*8 +: 8] <= val;
            end else if (offs == ezl_pkg::LC_TIMING_BLK) begin
                LOCAL_BUS_TIMING_SECOND[23:16] <=
                    val & ezl_pkg::LC_BLK_MASK;
            end else if (offs == ezl_pkg::LC_TIMING_TOP) begin
                LOCAL_BUS_TIMING_SECOND[31:24] <=
                    val & ezl_pkg::LC_TOP_MASK;
            end else if (offs == ezl_pkg::LC_IRQ_MASK_LO) begin
                GLOBAL_INTERRUPT_SUMMARY_MASK[7:0] <= val;
            end else if (offs == ezl_pkg::LC_IRQ_MASK_HI) begin
                GLOBAL_INTERRUPT_SUMMARY_MASK[15:8] <= val;
            end
        end
    end

    // zone2: identification bytes, reserved codes dropped
    always_ff @(posedge MCLK) begin
        if (RST) begin
            VENDOR_ID        <= ezl_pkg::VENDOR_ID_RST;
            SUBSYS_VENDOR_ID <= ezl_pkg::SUBVEND_ID_RST;
        end else if (state_reg == S_ZONE2 && WORD_DONE && !WORD_ABSENT
                     && offs <= ezl_pkg::ID_SUBVEND_HI) begin
            if (!offs[1])
                VENDOR_ID[offs[0]*8 +: 8] <= val;
            else
                SUBSYS_VENDOR_ID[offs[0]*8 +: 8] <= val;
        end
    end

    // zone3: per-function pci bytes; vendor bytes unreachable here
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DEVICE_ID   <= {2{ezl_pkg::DEVICE_ID_RST}};
            STATUS_BYTE <= {2{ezl_pkg::STATUS_RST}};
            CLASS_CODE  <= {2{ezl_pkg::CLASS_RST}};
            SUBSYS_ID   <= {2{ezl_pkg::SUBSYS_RST}};
            INT_PIN     <= {2{ezl_pkg::INT_PIN_RST}};
            PM_CAP      <= {2{ezl_pkg::PM_CAP_RST}};
        end else if (state_reg == S_FDATA && WORD_DONE && !WORD_ABSENT
                     && func_ok) begin
            if (offs == ezl_pkg::PC_DEVICE_LO) begin
                DEVICE_ID[fidx*16 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_DEVICE_HI) begin
                DEVICE_ID[fidx*16+8 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_STATUS) begin
                STATUS_BYTE[fidx*8 +: 8] <=
                    val & ezl_pkg::PC_STATUS_MASK;
            end else if (offs >= ezl_pkg::PC_CLASS_LO
                         && offs <= ezl_pkg::PC_CLASS_HI) begin
                CLASS_CODE[fidx*24 + (offs - ezl_pkg::PC_CLASS_LO)*8 +: 8]
                    <= val;
            end else if (offs == ezl_pkg::PC_SUBSYS_LO) begin
                SUBSYS_ID[fidx*16 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_SUBSYS_HI) begin
                SUBSYS_ID[fidx*16+8 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_INT_PIN) begin
                INT_PIN[fidx*8 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_PM_LO) begin
                PM_CAP[fidx*16 +: 8] <= val;
            end else if (offs == ezl_pkg::PC_PM_HI) begin
                PM_CAP[fidx*16+8 +: 8] <= val;
            end
        end
    end
endmodule : ezl_loader

// ===== sim/ezl_loader_chk.sv
// port-level assertion checker for the eeprom zone loader
`timescale 1ns/1ps
module ezl_loader_chk #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              MCLK,
    input wire logic              RST,
    // word reader
    input wire logic              WORD_REQ,
    input wire logic [ADDR_W-1:0] WORD_ADDR,
    input wire logic              WORD_DONE,
    input wire logic              WORD_ABSENT,
    input wire logic [15:0]       WORD_DATA,
    // configuration and status
    input wire logic [7:0]        LOCAL_CONTROL,
    input wire logic [31:0]       LOCAL_BUS_TIMING_SECOND,
    input wire logic [15:0]       STATUS_BYTE,
    input wire logic              PROGRAM_VALID,
    input wire logic              LOAD_DONE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_taken;
        WORD_REQ && WORD_DONE;
    endsequence
    sequence s_hdr;
        WORD_REQ && WORD_DONE && WORD_ADDR == '0 && !WORD_ABSENT;
    endsequence
    property p_start;
        $fell(RST) |-> ##[1:3] (WORD_REQ && WORD_ADDR == '0);
    endproperty
    a_start: assert property (p_start) else $error("no first read");
    property p_hold;
        WORD_REQ && !WORD_DONE |=> WORD_REQ && $stable(WORD_ADDR);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_next;
        s_taken ##1 WORD_REQ |-> WORD_ADDR == $past(WORD_ADDR) + 1'b1;
    endproperty
    a_next: assert property (p_next) else $error("address skipped");
    property p_valid;
        s_hdr ##0 WORD_DATA[15:4] == ezl_pkg::HDR_SIGNATURE |=> PROGRAM_VALID;
    endproperty
    a_valid: assert property (p_valid) else $error("valid not set");
    property p_badsig;
        s_hdr ##0 WORD_DATA[15:4] != ezl_pkg::HDR_SIGNATURE
            |=> LOAD_DONE && !PROGRAM_VALID && !WORD_REQ;
    endproperty
    a_badsig: assert property (p_badsig) else $error("bad image kept");
    property p_absent;
        WORD_DONE && WORD_ABSENT |=> LOAD_DONE && !WORD_REQ;
    endproperty
    a_absent: assert property (p_absent) else $error("absent ignored");
    property p_done_hold;
        LOAD_DONE |-> !WORD_REQ ##1 LOAD_DONE;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_masks;
        LOCAL_CONTROL[1:0] == 2'b00 && LOCAL_BUS_TIMING_SECOND[19:16] == 4'h0
            && !LOCAL_BUS_TIMING_SECOND[29] && (STATUS_BYTE & 16'hefef) == '0;
    endproperty
    a_masks: assert property (p_masks) else $error("zero bits set");
endmodule : ezl_loader_chk

// ===== sim/ezl_eeprom_model.sv
// behavioural word memory answering the loader's word requests
`timescale 1ns/1ps
module ezl_eeprom_model #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // word reader
    input  wire logic              req,
    input  wire logic [ADDR_W-1:0] addr,
    output logic                   done,
    output logic                   absent,
    output logic [15:0]            data,
    // behaviour
    input  wire logic              missing,
    input  wire logic [3:0]        lat
);
    logic [15:0] mem [256];
    logic [3:0]  cnt = 4'h0;
    int          reads = 0;
    initial begin
        done = 1'b0;
        absent = 1'b0;
        data = 16'h0000;
    end
    always @(posedge clk) begin
        if (rst || !req || done) begin
            cnt  <= 4'h0;
            done <= 1'b0;
        end else if (cnt >= lat) begin
            done   <= 1'b1;
            data   <= mem[addr];
            absent <= missing;
            reads  <= reads + 1;
        end else begin
            cnt <= cnt + 4'h1;
        end
        // lines are undriven after the answer: never show the old word
        if (done) data <= ~data;
        if (done) absent <= ~absent;
        if (rst) reads <= 0;
    end
endmodule : ezl_eeprom_model

// ===== sim/eeprom_config_zone_loader_tb_top.sv
// self-checking testbench for the eeprom zone loader
`timescale 1ns/1ps
module eeprom_config_zone_loader_tb_top;
    localparam logic [6:0] Z1 [14] = '{7'h00, 7'h04, 7'h05, 7'h06, 7'h08,
        7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h1e, 7'h1f};
    localparam logic [6:0] Z2 [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h7f};
    localparam logic [6:0] Z3 [11] = '{7'h02, 7'h03, 7'h06, 7'h09, 7'h0a,
        7'h0b, 7'h2e, 7'h2f, 7'h3d, 7'h42, 7'h43};
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        missing = 1'b0;
    logic [3:0]  lat = 4'h0;
    logic        req, done, absent, valid, ldone;
    logic [7:0]  addr, ctl;
    logic [15:0] wdata, irq, stat, vid, svid, ipin;
    logic [23:0] mpin;
    logic [31:0] t1, t2, dev, ssid, pm;
    logic [47:0] cls;
    int          err_count = 0;
    int          n_tests = 0;
    int          n = 0;

    always #20 mclk = ~mclk;

    ezl_loader #(.ADDR_W(8)) dut (.MCLK(mclk), .RST(rst), .WORD_REQ(req),
        .WORD_ADDR(addr), .WORD_DONE(done), .WORD_ABSENT(absent),
        .WORD_DATA(wdata), .LOCAL_CONTROL(ctl), .MULTIPURPOSE_PIN_CONFIG(mpin),
        .LOCAL_BUS_TIMING_FIRST(t1), .LOCAL_BUS_TIMING_SECOND(t2),
        .GLOBAL_INTERRUPT_SUMMARY_MASK(irq), .VENDOR_ID(vid),
        .SUBSYS_VENDOR_ID(svid), .DEVICE_ID(dev), .STATUS_BYTE(stat),
        .CLASS_CODE(cls), .SUBSYS_ID(ssid), .INT_PIN(ipin), .PM_CAP(pm),
        .PROGRAM_VALID(valid), .LOAD_DONE(ldone));
    ezl_eeprom_model #(.ADDR_W(8)) mdl (.clk(mclk), .rst(rst), .req(req),
        .addr(addr), .done(done), .absent(absent), .data(wdata),
        .missing(missing), .lat(lat));

    function automatic logic [7:0] v(input logic [6:0] o, input logic [7:0] k);
        return {1'b0, o} ^ k;
    endfunction : v

    task check(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task put(input logic [15:0] w);
        mdl.mem[n] = w;
        n++;
    endtask : put

    // reset, let the loader run the image, then count the words it read
    task run(input logic [3:0] l, input logic m, input int nw);
        int i;
        lat = l;
        missing = m;
        rst = 1'b1;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 4000 && ldone !== 1'b1; i++) @(negedge mclk);
        check(ldone, 1'b1);
        check(48'(mdl.reads), 48'(nw));
        n = 0;
    endtask : run

    task t_all;
        int i, f;
        logic [7:0] k;
        put({ezl_pkg::HDR_SIGNATURE, 4'h7});
        for (i = 0; i < 14; i++) put({i < 13, Z1[i], v(Z1[i], 8'he3)});
        for (i = 0; i < 6; i++) put({i < 5, Z2[i], v(Z2[i], 8'h5a)});
        for (f = 0; f < 2; f++) begin
            put({1'b1, 12'h000, f[2:0]});
            k = f ? 8'h99 : 8'h66;
            for (i = 0; i < 11; i++) put({i < 10, Z3[i], v(Z3[i], k)});
        end
        run(4'h3, 1'b0, 45);
        check(valid, 1'b1);
        check(ctl, v(7'h00, 8'he3) & 8'hfc);
        check(mpin, {v(7'h06, 8'he3), v(7'h05, 8'he3), v(7'h04, 8'he3)});
        check(t1, {v(7'h0b, 8'he3), v(7'h0a, 8'he3), v(7'h09, 8'he3),
            v(7'h08, 8'he3)});
        check(t2, {v(7'h0f, 8'he3) & 8'hdf, v(7'h0e, 8'he3) & 8'hf0,
            v(7'h0d, 8'he3), v(7'h0c, 8'he3)});
        check(irq, {v(7'h1f, 8'he3), v(7'h1e, 8'he3)});
        check(vid, {v(7'h01, 8'h5a), v(7'h00, 8'h5a)});
        check(svid, {v(7'h03, 8'h5a), v(7'h02, 8'h5a)});
        for (f = 0; f < 2; f++) begin
            k = f ? 8'h99 : 8'h66;
            check(dev[f*16+:16], {v(7'h03, k), v(7'h02, k)});
            check(stat[f*8+:8], v(7'h06, k) & 8'h10);
            check(pm[f*16+:16], {v(7'h43, k), v(7'h42, k)});
            check(cls[f*24+:24], {v(7'h0b, k), v(7'h0a, k), v(7'h09, k)});
            check(ssid[f*16+:16], {v(7'h2f, k), v(7'h2e, k)});
            check(ipin[f*8+:8], v(7'h3d, k));
        end
    endtask : t_all

    task t_skip;
        put({ezl_pkg::HDR_SIGNATURE, 4'h5});
        put(16'h0012);
        put(16'h8001);
        put(16'h3d07);
        put(16'h0000);
        run(4'h0, 1'b0, 5);
        check(ctl, 8'h10);
        check(vid, ezl_pkg::VENDOR_ID_RST);
        check(ipin, {8'h07, ezl_pkg::INT_PIN_RST});
    endtask : t_skip

    task t_reserved;
        put({ezl_pkg::HDR_SIGNATURE, 4'h1});
        put(16'h8005);
        put(16'h0211);
        put(16'h8000);
        put(16'h02aa);
        run(4'h1, 1'b0, 5);
        check(dev, {ezl_pkg::DEVICE_ID_RST, ezl_pkg::DEVICE_ID_RST[15:8],
            8'haa});
    endtask : t_reserved

    task t_bad;
        put({ezl_pkg::HDR_SIGNATURE ^ 12'h001, 4'h7});
        put(16'h8013);
        run(4'h1, 1'b0, 1);
        check(valid, 1'b0);
        check(ctl, ezl_pkg::LC_CONTROL_RST);
        put({ezl_pkg::HDR_SIGNATURE, 4'h7});
        run(4'h2, 1'b1, 1);
        check(valid, 1'b0);
    endtask : t_bad

    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    initial begin
        @(negedge mclk);
        t_all;
        t_skip;
        t_reserved;
        t_bad;
        stop_test;
    end

    // whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        stop_test;
    end
endmodule : eeprom_config_zone_loader_tb_top

bind ezl_loader ezl_loader_chk #(.ADDR_W(ADDR_W)) u_chk (.MCLK(MCLK),
    .RST(RST), .WORD_REQ(WORD_REQ), .WORD_ADDR(WORD_ADDR),
    .WORD_DONE(WORD_DONE), .WORD_ABSENT(WORD_ABSENT), .WORD_DATA(WORD_DATA),
    .LOCAL_CONTROL(LOCAL_CONTROL),
    .LOCAL_BUS_TIMING_SECOND(LOCAL_BUS_TIMING_SECOND),
    .STATUS_BYTE(STATUS_BYTE), .PROGRAM_VALID(PROGRAM_VALID),
    .LOAD_DONE(LOAD_DONE));
